// ### hdl/tlc_pkg.sv
// package: register map, field layout and reset-source codes for the limit timer control
package tlc_pkg;
  localparam logic [1:0] ADDR_LIMIT_CTRL  = 2'h0;
  localparam logic [1:0] ADDR_RST_SELECT  = 2'h1;
  localparam logic [1:0] ADDR_TIMER_CTRL  = 2'h2;
  localparam logic [1:0] ADDR_PERIOD      = 2'h3;
  localparam int         BIT_PRESCALE_SYNC_ENABLE        = 7;
  localparam int         BIT_CLOCK_EDGE_POLARITY        = 6;
  localparam int         BIT_ON_BIT_CLOCK_SYNC       = 5;
  localparam int         BIT_ON           = 0;
  localparam logic [7:0] LIMIT_CTRL_RST   = 8'h00;
  localparam logic [7:0] RST_SELECT_RST   = 8'h00;
  localparam logic [7:0] PERIOD_RST       = 8'hff;
  localparam logic [4:0] MODE_FREE_RUN    = 5'h00;
  localparam logic [4:0] MODE_ONE_SHOT    = 5'h08;
  localparam logic [4:0] RSEL_PIN         = 5'h00;
  localparam logic [4:0] RSEL_LAST_VALID  = 5'h11;
  localparam int         NUM_RST_SOURCES  = 18;
  localparam int         ON_SYNC_STAGES   = 2;

  typedef struct packed {
    logic       prescale_sync_enable;
    logic       clock_edge_polarity;
    logic       on_bit_clock_sync;
    logic [4:0] mode;
  } tlc_ctrl_s;

  function automatic logic tlc_rsel_valid(input logic [4:0] sel, input logic [4:0] own_code);
    tlc_rsel_valid = (sel <= RSEL_LAST_VALID) && !((sel == own_code) && (sel != RSEL_PIN));
  endfunction
endpackage

// ### hdl/tlc_edge_sync.sv
// edge detector with optional re-timing stage
`timescale 1ns/1ps
module tlc_edge_sync
  import tlc_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // control
  input  wire logic retime,
  input  wire logic falling,
  input  wire logic sig_in,
  // result
  output logic      edge_pulse
);
  logic s1_q, s2_q, prev_q, src;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= sig_in;
      s2_q <= s1_q;
    end
  end

  // raw input when not re-timed
  assign src = retime ? s2_q : sig_in;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= src;
    end
  end

  assign edge_pulse = falling ? (prev_q & ~src) : (~prev_q & src);
endmodule

// ### hdl/tlc_reset_mux.sv
// external reset source selector
`timescale 1ns/1ps
module tlc_reset_mux
  import tlc_pkg::*;
#(
  parameter logic [4:0] OWN_CODE = 5'h01
) (
  // selection
  input  wire logic [4:0]                 sel,
  input  wire logic [NUM_RST_SOURCES-1:0] sources,
  // result
  output logic                            ext_reset
);
  always_comb begin
    if (tlc_rsel_valid(sel, OWN_CODE)) begin
      ext_reset = sources[sel];
    end else begin
      ext_reset = 1'b0;
    end
  end
endmodule

// ### hdl/tlc_timer.sv
// limit timer control: registers, clock edge select, on-bit sync, count and reset select
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Operation
// - bit 7 re-times prescaler output to the system clock, else unsynchronised
// - bit 6 picks counting edge; software keeps it fixed while timer runs
// - bit 5 synchronises on bit; counting starts two input clocks later
// - five-bit mode field; on starts, off stops keeping the count
// - one-shot mode clears the on bit in hardware
// - count equal to period clears to zero on next counting clock
// - on bit clear holds timer off, resets the on-bit sync stages; count keeps its value unless an external reset clears it in a mode other than free run
module tlc_timer
  import tlc_pkg::*;
#(
  parameter logic [4:0] OWN_CODE = 5'h01
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       arst_n,
  // register port
  input  wire logic [1:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic [7:0]                      reg_rdata,
  // timer input clock from prescaler
  input  wire logic                       prescaled_clk,
  // reset sources, index equals select code
  input  wire logic [NUM_RST_SOURCES-1:0] reset_sources,
  // status
  output logic [7:0]                      timer_count,
  output logic                            period_match,
  output logic                            timer_running
);
  tlc_ctrl_s  ctrl_q;
  logic [4:0] rsel_q;
  logic [7:0] period_q;
  logic [7:0] count_q;
  logic       on_q;
  logic       one_shot_done;
  logic       count_edge;
  logic       ext_reset;
  logic [ON_SYNC_STAGES-1:0] on_sh_q;
  logic       run;

  tlc_edge_sync u_edge (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .retime     (ctrl_q.prescale_sync_enable),
    .falling    (ctrl_q.clock_edge_polarity),
    .sig_in     (prescaled_clk),
    .edge_pulse (count_edge)
  );

  tlc_reset_mux #(
    .OWN_CODE (OWN_CODE)
  ) u_rst (
    .sel       (rsel_q),
    .sources   (reset_sources),
    .ext_reset (ext_reset)
  );

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q   <= tlc_ctrl_s'(LIMIT_CTRL_RST);
      rsel_q   <= RST_SELECT_RST[4:0];
      period_q <= PERIOD_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_LIMIT_CTRL: ctrl_q   <= tlc_ctrl_s'(reg_wdata);
        ADDR_RST_SELECT: rsel_q   <= reg_wdata[4:0];
        ADDR_PERIOD:     period_q <= reg_wdata;
        default:         ;
      endcase
    end
  end

  assign one_shot_done = (ctrl_q.mode == MODE_ONE_SHOT) && run && count_edge
                         && (count_q == period_q);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      on_q <= 1'b0;
    end else if (reg_wr && (reg_addr == ADDR_TIMER_CTRL)) begin
      on_q <= reg_wdata[BIT_ON];
    end else if (one_shot_done) begin
      on_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      on_sh_q <= '0;
    end else if (!on_q) begin
      on_sh_q <= '0;
    end else if (count_edge) begin
      on_sh_q <= {on_sh_q[ON_SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign run = on_q && (!ctrl_q.on_bit_clock_sync || on_sh_q[ON_SYNC_STAGES-1]);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= 8'h00;
    end else if (ctrl_q.mode != MODE_FREE_RUN && ext_reset) begin
      count_q <= 8'h00;
    end else if (run && count_edge) begin
      if (count_q == period_q) begin
        count_q <= 8'h00;
      end else begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_LIMIT_CTRL: reg_rdata <= ctrl_q;
        ADDR_RST_SELECT: reg_rdata <= {3'h0, rsel_q};
        ADDR_TIMER_CTRL: reg_rdata <= {7'h00, on_q};
        ADDR_PERIOD:     reg_rdata <= period_q;
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign timer_count   = count_q;
  assign period_match  = (count_q == period_q);
  assign timer_running = run;
endmodule

// ### test/tlc_properties.sv
// port assertions for the limit timer
`timescale 1ns/1ps
module tlc_properties
  import tlc_pkg::*;
(
  // watched ports
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] timer_count,
  input wire logic       period_match,
  input wire logic       timer_running
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("data outside read slot");
  sel_high_a: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_RST_SELECT
    |-> reg_rdata[7:5] == 3'h0) else $error("select upper bits set");
  sel_back_a: assert property (reg_wr && reg_addr == ADDR_RST_SELECT ##1 reg_rd
    && reg_addr == ADDR_RST_SELECT |=> reg_rdata == {3'h0, $past(reg_wdata[4:0], 2)})
    else $error("select readback wrong");
  ctrl_back_a: assert property (reg_wr && reg_addr[0] == reg_addr[1] ##1 reg_rd
    && reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("register readback wrong");
  count_step_a: assert property ($changed(timer_count) |-> timer_count == 8'h00
    || timer_count == $past(timer_count) + 8'h01) else $error("count jumped");
  match_clear_a: assert property ($past(period_match) && $changed(timer_count)
    |-> timer_count == 8'h00) else $error("no clear after match");
  match_cmp_a: assert property (reg_wr && reg_addr == ADDR_PERIOD ##1 $stable(timer_count)
    |-> period_match == (timer_count == $past(reg_wdata))) else $error("match flag wrong");
  off_hold_a: assert property (!$past(timer_running) && !$past(timer_running, 2)
    |-> $stable(timer_count) || timer_count == 8'h00) else $error("count moved while off");
endmodule

// ### test/tlc_partner.sv
// peripheral side: prescaled clock and registered reset source levels
`timescale 1ns/1ps
module tlc_partner
  import tlc_pkg::*;
#(
  parameter int HALF = 3
) (
  // control from bench
  input  wire logic                       ref_clk,
  input  wire logic                       run,
  input  wire logic [NUM_RST_SOURCES-1:0] lvl,
  // to the timer
  output logic                            pclk,
  output logic [NUM_RST_SOURCES-1:0]      srcs
);
  int n = 0;
  initial pclk = 1'b0;
  initial srcs = '0;
  // clock stands still unless run
  always @(posedge ref_clk) begin
    srcs <= lvl;
    n = (n + 1) % HALF;
    if (run && n == 0) pclk <= ~pclk;
  end
endmodule

// ### test/tlc_timer_bench.sv
// self-checking bench for the limit timer control
`timescale 1ns/1ps
module tlc_timer_bench
  import tlc_pkg::*;
;
  logic                       ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic                       run = 1'b0, period_match, timer_running, prescaled_clk;
  logic [1:0]                 reg_addr = 2'h0;
  logic [7:0]                 reg_wdata = 8'h00, reg_rdata, timer_count;
  logic [NUM_RST_SOURCES-1:0] reset_sources, lvl = '0;
  int                         errors = 0, check_count = 0;
  localparam logic [4:0]      OWN_CODE = 5'h01;
  always #5 ref_clk = ~ref_clk;
  tlc_timer #(.OWN_CODE(OWN_CODE)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prescaled_clk(prescaled_clk),
    .reset_sources(reset_sources), .timer_count(timer_count), .period_match(period_match),
    .timer_running(timer_running));
  tlc_partner u_far (.ref_clk(ref_clk), .run(run), .lvl(lvl), .pclk(prescaled_clk),
    .srcs(reset_sources));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, r, a, d};
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    #1 chk(reg_rdata, e);
  endtask
  task automatic wcnt(input logic [7:0] e);
    int i;
    bus(1'b0, 1'b0, reg_addr, 8'h00);
    for (i = 0; i < 400 && timer_count !== e; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(timer_count, e);
    if (i == 400) finish_test();
  endtask
  task automatic t_regs();
    rd(ADDR_LIMIT_CTRL, LIMIT_CTRL_RST);
    rd(ADDR_RST_SELECT, RST_SELECT_RST);
    rd(ADDR_PERIOD, PERIOD_RST);
    wr(ADDR_RST_SELECT, 8'hff);
    rd(ADDR_RST_SELECT, 8'h1f);
    wr(ADDR_LIMIT_CTRL, 8'he8);
    rd(ADDR_LIMIT_CTRL, 8'he8);
    $display("regs done");
  endtask
  task automatic t_count();
    wr(ADDR_LIMIT_CTRL, {3'h7, MODE_FREE_RUN});
    wr(ADDR_PERIOD, 8'h03);
    wr(ADDR_TIMER_CTRL, 8'h01);
    run <= 1'b1;
    wcnt(8'h03);
    wcnt(8'h00);
    wr(ADDR_TIMER_CTRL, 8'h00);
    rd(ADDR_TIMER_CTRL, 8'h00);
    chk({7'h00, timer_running}, 8'h00);
    $display("count done");
  endtask
  task automatic t_shot();
    wr(ADDR_LIMIT_CTRL, {3'h0, MODE_ONE_SHOT});
    wr(ADDR_PERIOD, 8'h02);
    wr(ADDR_TIMER_CTRL, 8'h01);
    wcnt(8'h02);
    for (int i = 0; i < 20 && timer_running !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    rd(ADDR_TIMER_CTRL, 8'h00);
    chk(timer_count, 8'h00);
    $display("one-shot done");
  endtask
  task automatic t_ext();
    logic [4:0] c [3] = '{5'h12, OWN_CODE, 5'h1f};
    wr(ADDR_LIMIT_CTRL, 8'h01);
    wr(ADDR_PERIOD, 8'hff);
    wr(ADDR_TIMER_CTRL, 8'h01);
    for (int k = 0; k < NUM_RST_SOURCES; k++) begin
      if (k == OWN_CODE) continue;
      wr(ADDR_RST_SELECT, 8'(k));
      lvl <= '0;
      wcnt(timer_count + 8'h01);
      lvl <= 18'h00001 << k;
      wcnt(8'h00);
    end
    lvl <= '0;
    foreach (c[k]) begin
      wr(ADDR_RST_SELECT, {3'h0, c[k]});
      lvl <= '1;
      wcnt(timer_count + 8'h02);
    end
    $display("reset select done");
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_count();
    t_shot();
    t_ext();
    finish_test();
  end
endmodule
bind tlc_timer tlc_properties u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .timer_count(timer_count), .period_match(period_match), .timer_running(timer_running));
